/* hdl/field_sensor_pkg.sv */
// shared constants, field layouts and carrier types for the field sensor core
package field_sensor_pkg;
    // supply-line bit timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int BIT_TIME_NS = 1000;
    localparam int BIT_CYC = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] BIT_CYC_C = 8'(BIT_CYC);
    localparam logic [7:0] START_CYC_C = 8'(BIT_CYC + BIT_CYC / 2);
    localparam logic [4:0] CMD_BITS_C = 5'h14;
    localparam logic [4:0] REPLY_BITS_C = 5'h11;

    // word addresses carried in a command
    localparam logic [2:0] ADDR_GAIN_OFFSET = 3'h0;
    localparam logic [2:0] ADDR_RANGE_TEMPCO_LOCK = 3'h1;
    localparam logic [2:0] ADDR_PROD_INFO_A = 3'h2;
    localparam logic [2:0] ADDR_PROD_INFO_B = 3'h3;
    localparam logic [2:0] ADDR_MEASURED = 3'h4;

    // gain_offset_word layout
    localparam int OFFSET_LSB = 0;
    localparam int GAIN_LSB = 8;
    // range_tempco_lock_word layout, bit 15 reserved
    localparam int RANGE_LSB = 0;
    localparam int TC_LSB = 3;
    localparam int QUADRATIC_TEMP_COEFF_LSB = 8;
    localparam int OFFSET_ALIGNMENT_FLAG_BIT = 13;
    localparam int LOCK_BIT = 14;

    localparam logic [15:0] WORD_ERASED = 16'h0000;
    localparam logic [9:0] DIAG_CODE = 10'h000;
    localparam logic [9:0] MID_CODE = 10'h200;
    localparam logic signed [9:0] RESULT_MAX = 10'sh1ff;
    localparam logic signed [9:0] RESULT_MIN = -10'sh200;

    // fixed-point scaling: gain 1.0 = 64, tempco factor 1.0 = 4096
    localparam int GAIN_FRAC = 6;
    localparam int TC_FRAC = 12;
    localparam int QUADRATIC_TEMP_COEFF_SHIFT = 6;
    localparam logic signed [21:0] TC_UNITY = 22'sh001000;

    typedef struct packed {
        logic signed [7:0] gain;
        logic signed [7:0] offset;
        logic [2:0] field_range_select;
        logic signed [4:0] linear_temp_coeff;
        logic signed [4:0] quadratic_temp_coeff;
        logic offset_alignment_flag;
        logic user_lock_flag;
    } dsp_cfg_t;

    typedef struct packed {
        logic write;
        logic [2:0] addr;
        logic [15:0] data;
    } cmd_t;

    function automatic dsp_cfg_t decode_cfg(input logic [15:0] w0, input logic [15:0] w1);
        dsp_cfg_t c;
        c.gain = w0[GAIN_LSB +: 8];
        c.offset = w0[OFFSET_LSB +: 8];
        c.field_range_select = w1[RANGE_LSB +: 3];
        c.linear_temp_coeff = w1[TC_LSB +: 5];
        c.quadratic_temp_coeff = w1[QUADRATIC_TEMP_COEFF_LSB +: 5];
        c.offset_alignment_flag = w1[OFFSET_ALIGNMENT_FLAG_BIT];
        c.user_lock_flag = w1[LOCK_BIT];
        return c;
    endfunction
endpackage

/* hdl/field_dsp_core.sv */
// offset adder, temperature-compensated gain multiplier and overflow check
`timescale 1ns/1ns
module field_dsp_core
    import field_sensor_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input field_sensor_pkg::dsp_cfg_t cfg_i,
    input wire logic signed [9:0] sample_i,
    input wire logic sample_valid_i,
    input wire logic signed [7:0] temp_i,
    output logic signed [9:0] result_o,
    output logic overflow_o,
    output logic result_valid_o
);
    logic signed [9:0] off_ext;
    logic signed [10:0] diff;
    logic signed [21:0] lin;
    logic signed [21:0] quad;
    logic signed [21:0] factor;
    logic signed [29:0] gain_raw;
    logic signed [17:0] eff_gain;
    logic signed [28:0] prod;
    logic signed [22:0] scaled;

    // msb-aligned offset covers full scale, lsb-aligned a quarter of it
    assign off_ext = cfg_i.offset_alignment_flag ? {cfg_i.offset, 2'b00}
                                                 : {{2{cfg_i.offset[7]}}, cfg_i.offset}; // R14
    assign diff = 11'(sample_i) - 11'(off_ext); // R13 R19
    assign lin = 22'(cfg_i.linear_temp_coeff * temp_i); // R17
    assign quad = 22'((cfg_i.quadratic_temp_coeff * temp_i * temp_i) >>> QUADRATIC_TEMP_COEFF_SHIFT); // R17
    assign factor = TC_UNITY + lin + quad;
    assign gain_raw = 30'(cfg_i.gain * factor);
    assign eff_gain = 18'(gain_raw >>> TC_FRAC); // R11
    assign prod = 29'(eff_gain * diff); // R19
    assign scaled = 23'(prod >>> GAIN_FRAC); // R12

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            result_o <= '0;
            overflow_o <= 1'b0;
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= sample_valid_i;
            if (sample_valid_i) begin
                // saturate so the stored value stays the nearest legal one
                if (scaled > 23'(RESULT_MAX)) begin
                    result_o <= RESULT_MAX;
                    overflow_o <= 1'b1; // R02
                end else if (scaled < 23'(RESULT_MIN)) begin
                    result_o <= RESULT_MIN;
                    overflow_o <= 1'b1; // R02
                end else begin
                    result_o <= 10'(scaled);
                    overflow_o <= 1'b0;
                end
            end
        end
    end
endmodule

/* hdl/field_sensor_dsp_config.sv */
// field sensor core: signal path, configuration words and supply-line access
//
// Notes on behaviour
// R01: sample conditioned by settings, drives dac
// R02: arithmetic, adc or heat fault forces diagnostic band
// R03: lock refuses programming, never clearable; nvm_erase_i clears the stored lock bit and the next rst_i unlocks
// R04: supply-line commands read/write, answer on output
// R05: programming only via supply line, unlocked
// R06: negative gain: south field raises output
// R07: measured value read-only, 10 valid signed bits
// R08: gain one: north field increases measured value
// R09: four 16-bit configuration words
// R10: first word holds gain and offset
// R11: gain -2 to 2 in 1/64 steps
// R12: gain one maps adc full scale
// R13: offset is adder term, zero-field level
// R14: alignment flag scales offset span by four
// R15: second word: range, tempcos, alignment, lock
// R16: range code selects adc field range
// R17: tempcos shape gain slope and curvature
// R18: third and fourth words factory, read-only
// R19: result is gain times sample minus offset
// R20: lock effective after power cycle; reads answered
// R21: measured value refreshed every conversion
`timescale 1ns/1ns
module field_sensor_dsp_config
    import field_sensor_pkg::*;
#(
    // production words, values arbitrary
    parameter logic [15:0] PROD_INFO_A = 16'h0000,
    parameter logic [15:0] PROD_INFO_B = 16'h0000
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic supply_program_line_i,
    input wire logic nvm_erase_i,
    input wire logic signed [9:0] adc_sample_i,
    input wire logic adc_valid_i,
    input wire logic adc_range_fault_i,
    input wire logic overtemp_i,
    input wire logic signed [7:0] temp_i,
    output logic [2:0] field_range_select_o,
    output logic [9:0] dac_code_o,
    output logic diagnostic_output_band_o,
    output logic [15:0] measured_field_value_o,
    output logic lock_active_o,
    output logic answer_en_o,
    output logic answer_o
);
    import field_sensor_pkg::*;

    typedef enum {
        ST_IDLE,
        ST_START,
        ST_RX,
        ST_EXEC,
        ST_TX
    } link_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // nonvolatile words
    ////////////////////////////////////////////////////////////////////////////

    logic [15:0] nvm_q [0:1];
    logic lock_active_q;
    dsp_cfg_t cfg;
    cmd_t cmd;
    logic write_ok;

    assign cfg = decode_cfg(nvm_q[0], nvm_q[1]); // R10 R15

    // storage survives rst_i like eeprom; only the factory erase clears it
    always_ff @(posedge clk_sys_i) begin
        if (nvm_erase_i) begin
            nvm_q[0] <= WORD_ERASED;
            nvm_q[1] <= WORD_ERASED;
        end else if (write_ok) begin
            nvm_q[cmd.addr[0]] <= cmd.data; // R09
        end
    end

    // lock taken only at power-up, so a fresh lock bit waits for a cycle
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            lock_active_q <= nvm_q[1][LOCK_BIT]; // R20
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // supply-line receiver
    ////////////////////////////////////////////////////////////////////////////

    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic line_q;
    logic line_rise;
    link_state_t state_q;
    logic [7:0] cnt_q;
    logic [4:0] nbits_q;
    logic [19:0] shift_q;
    logic [16:0] reply_q;
    logic [16:0] reply_d;
    logic tick;
    logic rx_slot;
    logic tx_slot;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= supply_program_line_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // a level change counts only once two stages agree
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            line_q <= 1'b0;
        end else if (sync2_q == sync3_q) begin
            line_q <= sync3_q;
        end
    end

    assign line_rise = sync2_q & sync3_q & ~line_q;
    assign tick = (cnt_q == 8'h00);
    assign rx_slot = tick && (state_q == ST_START || state_q == ST_RX);
    assign tx_slot = tick && (state_q == ST_TX);
    assign cmd = shift_q;

    // programming is accepted only while unlocked, and only words 0 and 1
    assign write_ok = (state_q == ST_EXEC) && cmd.write && !lock_active_q
                      && (cmd.addr == ADDR_GAIN_OFFSET
                          || cmd.addr == ADDR_RANGE_TEMPCO_LOCK); // R03 R05 R18

    ////////////////////////////////////////////////////////////////////////////
    // command sequencer
    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        reply_d = '0;
        if (cmd.write) begin
            // echo the word with an acknowledge bit, zero when refused
            reply_d = {write_ok, cmd.data}; // R03 R20
        end else begin
            case (cmd.addr)
                ADDR_GAIN_OFFSET: reply_d = {1'b1, nvm_q[0]}; // R04
                ADDR_RANGE_TEMPCO_LOCK: reply_d = {1'b1, nvm_q[1]}; // R04
                ADDR_PROD_INFO_A: reply_d = {1'b1, PROD_INFO_A}; // R18
                ADDR_PROD_INFO_B: reply_d = {1'b1, PROD_INFO_B}; // R18
                ADDR_MEASURED: reply_d = {1'b1, measured_field_value_o}; // R07
                default: reply_d = '0;
            endcase
        end
    end

    // every phase but idle and exec ends on the bit timer
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (line_rise) begin
                        state_q <= ST_START;
                    end
                end
                ST_START: begin
                    if (tick) begin
                        state_q <= ST_RX;
                    end
                end
                ST_RX: begin
                    if (tick && nbits_q == CMD_BITS_C - 5'h01) begin
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_q <= ST_TX;
                end
                ST_TX: begin
                    // line activity during the answer is ignored
                    if (tx_slot && nbits_q == REPLY_BITS_C - 5'h01) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // first sample lands mid-way through the first data bit
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
        end else if (state_q == ST_IDLE) begin
            if (line_rise) begin
                cnt_q <= START_CYC_C - 8'h01;
            end
        end else if (tick || state_q == ST_EXEC) begin
            cnt_q <= BIT_CYC_C - 8'h01;
        end else begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    // one bit counter serves both the command and the answer
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            nbits_q <= 5'h00;
        end else if (state_q == ST_EXEC) begin
            nbits_q <= 5'h00;
        end else if (tick && state_q == ST_START) begin
            nbits_q <= 5'h01;
        end else if (rx_slot || tx_slot) begin
            nbits_q <= nbits_q + 5'h01;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            shift_q <= '0;
        end else if (rx_slot) begin
            shift_q <= {shift_q[18:0], line_q}; // R04
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reply_q <= '0;
        end else if (state_q == ST_EXEC) begin
            reply_q <= reply_d; // R04
        end else if (tx_slot) begin
            reply_q <= {reply_q[15:0], 1'b0};
        end
    end

    // answer shares the output pin; enable marks the digital reply
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            answer_en_o <= 1'b0;
            answer_o <= 1'b0;
        end else begin
            answer_en_o <= (state_q == ST_TX); // R04
            answer_o <= (state_q == ST_TX) && reply_q[16]; // R04
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // signal path
    ////////////////////////////////////////////////////////////////////////////

    logic signed [9:0] dsp_result;
    logic dsp_ovf;
    logic dsp_valid;
    logic adc_fault_q;
    logic sample_err_q;
    logic [9:0] code_q;

    // the sample counts north fields positive, so positive gain raises
    // the measured value for north and negative gain for south
    field_dsp_core u_dsp (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .cfg_i(cfg),
        .sample_i(adc_sample_i),
        .sample_valid_i(adc_valid_i),
        .temp_i(temp_i),
        .result_o(dsp_result),
        .overflow_o(dsp_ovf),
        .result_valid_o(dsp_valid)
    ); // R01 R06 R08 R12 R19

    // align the converter fault with the one-cycle dsp latency
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            adc_fault_q <= 1'b0;
        end else if (adc_valid_i) begin
            adc_fault_q <= adc_range_fault_i; // R02
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            measured_field_value_o <= 16'h0000;
        end else if (dsp_valid) begin
            measured_field_value_o <= {{6{dsp_result[9]}}, dsp_result}; // R07 R21
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            code_q <= MID_CODE;
        end else if (dsp_valid) begin
            code_q <= {~dsp_result[9], dsp_result[8:0]}; // R01 R06
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sample_err_q <= 1'b0;
        end else if (dsp_valid) begin
            sample_err_q <= dsp_ovf | adc_fault_q; // R02
        end
    end

    // overtemperature acts at once, not only at the next sample
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dac_code_o <= DIAG_CODE;
            diagnostic_output_band_o <= 1'b0;
        end else if (sample_err_q || overtemp_i) begin
            dac_code_o <= DIAG_CODE; // R02
            diagnostic_output_band_o <= 1'b1; // R02
        end else begin
            dac_code_o <= code_q; // R01
            diagnostic_output_band_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            field_range_select_o <= 3'h0;
        end else begin
            field_range_select_o <= cfg.field_range_select; // R16
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            lock_active_o <= 1'b0;
        end else begin
            lock_active_o <= lock_active_q; // R03
        end
    end
endmodule

/* verification/supply_programmer.sv */
// programmer model: modulates the supply line, collects the pin reply
`timescale 1ns/1ns
module supply_programmer (
    input wire logic clk_sys_i,
    input wire logic answer_en_i,
    input wire logic answer_i,
    output logic line_o
);
    initial line_o = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic w, input logic [2:0] a, input logic [15:0] d,
                        output logic ack, output logic [15:0] q, output bit ok);
        logic [20:0] f;
        logic [16:0] r;
        int n;
        f = {1'b1, w, a, d};
        r = '0;
        n = 0;
        for (int i = 20; i >= 0; i--) begin
            line_o = f[i];
            repeat (20) @(negedge clk_sys_i);
        end
        // back to low so the next frame shows a fresh rise
        line_o = 1'b0;
        while (!answer_en_i && n < 200) begin
            @(negedge clk_sys_i);
            n++;
        end
        ok = answer_en_i;
        for (int i = 16; i >= 0; i--) begin
            repeat ((i == 16) ? 10 : 20) @(negedge clk_sys_i);
            r[i] = answer_i;
        end
        {ack, q} = r;
        n = 0;
        while (answer_en_i && n < 100) begin
            @(negedge clk_sys_i);
            n++;
        end
        ok = ok && !answer_en_i;
        @(negedge clk_sys_i);
    endtask
endmodule

/* verification/field_sensor_assertions.sv */
// port-level checks for the field sensor core
`timescale 1ns/1ns
module field_sensor_assertions (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic adc_valid_i,
    input wire logic adc_range_fault_i,
    input wire logic overtemp_i,
    input wire logic [9:0] dac_code_o,
    input wire logic diagnostic_output_band_o,
    input wire logic [15:0] measured_field_value_o,
    input wire logic lock_active_o,
    input wire logic answer_en_o,
    input wire logic answer_o
);
    logic [8:0] ans_cnt_q;
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !answer_en_o) begin
            ans_cnt_q <= '0;
        end else begin
            ans_cnt_q <= ans_cnt_q + 9'h001;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // lone sample: no newer sample can overwrite before the dac settles
    sequence lone_sample;
        adc_valid_i ##1 !adc_valid_i [*3];
    endsequence
    sequence faulty_sample;
        adc_valid_i && adc_range_fault_i;
    endsequence
    diag_dac_zero_a: assert property (
        diagnostic_output_band_o |-> dac_code_o == 10'h000) else $error("diag dac");
    overtemp_diag_a: assert property (
        overtemp_i |=> diagnostic_output_band_o && dac_code_o == 10'h000)
        else $error("overtemp ignored");
    adc_fault_a: assert property (
        faulty_sample |-> ##3 diagnostic_output_band_o) else $error("adc fault ignored");
    dac_follows_a: assert property (
        lone_sample |-> diagnostic_output_band_o
        || dac_code_o == (measured_field_value_o[9:0] ^ 10'h200)) else $error("dac code");
    value_sext_a: assert property (
        measured_field_value_o[15:10] == {6{measured_field_value_o[9]}})
        else $error("measured not sign extended");
    value_refresh_a: assert property (
        $changed(measured_field_value_o) |-> $past(adc_valid_i, 2))
        else $error("measured moved without sample");
    reply_idle_a: assert property (
        !answer_en_o |-> !answer_o) else $error("reply bit outside reply");
    reply_length_a: assert property (
        $fell(answer_en_o) |-> ans_cnt_q == 9'h154) else $error("reply length");
    reply_bit_a: assert property (
        answer_en_o && $past(answer_en_o) && $changed(answer_o)
        |-> ans_cnt_q % 9'h014 == 9'h000) else $error("reply bit timing");
    // the first edge after release loads the captured lock, so skip two edges
    lock_hold_a: assert property (
        !$past(rst_i) && !$past(rst_i, 2) |-> $stable(lock_active_o))
        else $error("lock moved");
endmodule
bind field_sensor_dsp_config field_sensor_assertions u_chk (.clk_sys_i, .rst_i,
    .adc_valid_i, .adc_range_fault_i, .overtemp_i, .dac_code_o, .diagnostic_output_band_o,
    .measured_field_value_o, .lock_active_o, .answer_en_o, .answer_o);

/* verification/tb_top.sv */
// self-checking bench for the field sensor core
`timescale 1ns/1ns
module tb_top;
    import field_sensor_pkg::*;
    localparam logic [15:0] INFO_A = 16'h5a3c; // arbitrary
    localparam logic [15:0] INFO_B = 16'hc3a5; // arbitrary
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic erase = 1'b1;
    logic [9:0] smp = '0;
    logic vld = 1'b0;
    logic flt = 1'b0;
    logic hot = 1'b0;
    logic [7:0] tmp = '0;
    logic line;
    logic [2:0] rng;
    logic [9:0] dac;
    logic diag;
    logic [15:0] meas;
    logic lock;
    logic aen;
    logic ans;
    int err_total = 0;
    int check_count = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    field_sensor_dsp_config #(.PROD_INFO_A(INFO_A), .PROD_INFO_B(INFO_B)) u_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .supply_program_line_i(line),
        .nvm_erase_i(erase), .adc_sample_i(smp), .adc_valid_i(vld),
        .adc_range_fault_i(flt), .overtemp_i(hot), .temp_i(tmp),
        .field_range_select_o(rng), .dac_code_o(dac), .diagnostic_output_band_o(diag),
        .measured_field_value_o(meas), .lock_active_o(lock), .answer_en_o(aen),
        .answer_o(ans));
    supply_programmer u_prog (.clk_sys_i(clk_sys_i), .answer_en_i(aen),
        .answer_i(ans), .line_o(line));
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic w, input logic [2:0] a, input logic [15:0] d,
                       input logic eack, input logic [15:0] ed);
        logic ack;
        logic [15:0] q;
        bit ok;
        u_prog.xfer(w, a, d, ack, q, ok);
        if (!ok) begin
            chk(16'h0000, 16'h0001);
            complete_run();
        end
        chk({15'h0, ack}, {15'h0, eack});
        chk(q, ed);
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        cmd(1'b1, a, d, 1'b1, d);
    endtask
    // cm low skips the value, which is unspecified in the diagnostic band
    task automatic samp(input logic [9:0] s, input logic f, input bit cm,
                        input logic [15:0] em, input logic [9:0] ed, input logic eg);
        smp = s;
        flt = f;
        vld = 1'b1;
        @(negedge clk_sys_i);
        vld = 1'b0;
        flt = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        if (cm) begin
            chk(meas, em);
        end
        chk({6'h0, dac}, {6'h0, ed});
        chk({15'h0, diag}, {15'h0, eg});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        chk({12'h0, lock, rng}, 16'h0000);
        wr(3'h0, 16'h4000);
        wr(3'h1, 16'h0005);
        cmd(1'b0, 3'h0, 16'h0000, 1'b1, 16'h4000);
        cmd(1'b0, 3'h1, 16'h0000, 1'b1, 16'h0005);
        cmd(1'b0, 3'h2, 16'h0000, 1'b1, INFO_A);
        cmd(1'b1, 3'h3, 16'h1111, 1'b0, 16'h1111);
        cmd(1'b0, 3'h3, 16'h0000, 1'b1, INFO_B);
        cmd(1'b1, 3'h4, 16'h1234, 1'b0, 16'h1234);
        cmd(1'b0, 3'h5, 16'h0000, 1'b0, 16'h0000);
    endtask
    task automatic t_path();
        samp(10'h064, 1'b0, 1'b1, 16'h0064, 10'h264, 1'b0);
        samp(10'h338, 1'b0, 1'b1, 16'hff38, 10'h138, 1'b0);
        samp(10'h1ff, 1'b0, 1'b1, 16'h01ff, 10'h3ff, 1'b0);
        samp(10'h200, 1'b0, 1'b1, 16'hfe00, 10'h000, 1'b0);
        cmd(1'b0, 3'h4, 16'h0000, 1'b1, 16'hfe00);
        wr(3'h0, 16'hc000);
        samp(10'h064, 1'b0, 1'b1, 16'hff9c, 10'h19c, 1'b0);
        wr(3'h0, 16'h4010);
        samp(10'h064, 1'b0, 1'b1, 16'h0054, 10'h254, 1'b0);
        wr(3'h1, 16'h2005);
        samp(10'h064, 1'b0, 1'b1, 16'h0024, 10'h224, 1'b0);
        wr(3'h1, 16'h0005);
        wr(3'h0, 16'h7f00);
        samp(10'h1ff, 1'b0, 1'b0, 16'h0000, 10'h000, 1'b1);
        samp(10'h200, 1'b0, 1'b0, 16'h0000, 10'h000, 1'b1);
    endtask
    task automatic t_fault();
        wr(3'h0, 16'h4000);
        samp(10'h00a, 1'b1, 1'b0, 16'h0000, 10'h000, 1'b1);
        samp(10'h00a, 1'b0, 1'b1, 16'h000a, 10'h20a, 1'b0);
        hot = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        chk({5'h0, diag, dac}, 16'h0400);
        hot = 1'b0;
        samp(10'h014, 1'b0, 1'b1, 16'h0014, 10'h214, 1'b0);
    endtask
    task automatic t_temp();
        tmp = 8'h40;
        wr(3'h1, 16'h0015);
        samp(10'h064, 1'b0, 1'b1, 16'h0067, 10'h267, 1'b0);
        wr(3'h1, 16'h0105);
        samp(10'h064, 1'b0, 1'b1, 16'h0065, 10'h265, 1'b0);
        tmp = 8'h00;
    endtask
    task automatic t_lock();
        wr(3'h1, 16'h4005);
        wr(3'h0, 16'h4000);
        chk({15'h0, lock}, 16'h0000);
        rst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        rst_i = 1'b0;
        @(negedge clk_sys_i);
        chk({12'h0, lock, rng}, 16'h000d);
        cmd(1'b1, 3'h0, 16'h1234, 1'b0, 16'h1234);
        cmd(1'b1, 3'h1, 16'h0005, 1'b0, 16'h0005);
        cmd(1'b0, 3'h0, 16'h0000, 1'b1, 16'h4000);
        cmd(1'b0, 3'h1, 16'h0000, 1'b1, 16'h4005);
    endtask
    initial begin
        repeat (2) @(negedge clk_sys_i);
        erase = 1'b0;
        repeat (14) @(negedge clk_sys_i);
        rst_i = 1'b0;
        @(negedge clk_sys_i);
        t_regs();
        t_path();
        t_fault();
        t_temp();
        t_lock();
        complete_run();
    end
endmodule
